/* logic/pcrp_pkg.sv */
/*
  pcrp_pkg: shared constants and types for the parallel cpu register port.
  assumes: both ends and the bench share one 100 MHz clock named clk.
*/
package pcrp_pkg;

  // ------------------------------------------------------------
  // bus widths
  // ------------------------------------------------------------
  localparam int ADDR_W = 8;   // direct register index width
  localparam int DATA_W = 8;   // data bus width

  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int CLK_PERIOD_NS   = 10;     // system clock period
  localparam int RESET_MIN_NS    = 5000;   // least reset pulse, 5 us
  // least reset hold in cycles, rounded up
  localparam int RESET_MIN_CYC   = (RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SYNC_MARGIN_NS  = 5;      // fixed margin on top of two bus clocks
  localparam int SYNC_ACC_PERIODS = 2;     // bus clock periods allowed for completion
  localparam int PCLK_MIN_NS     = 15;     // least bus clock period
  localparam int ASYNC_ACC_NS    = 65;     // strobe to completion, async
  // async access budget in cycles, rounded down
  localparam int ASYNC_ACC_CYC   = ASYNC_ACC_NS / CLK_PERIOD_NS;
  localparam int STROBE_MIN_NS   = 70;     // least strobe width, async
  localparam int STROBE_MIN_CYC  = (STROBE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BCLK_DIV        = 2;      // host bus clock = clk / (2*BCLK_DIV)

  // ------------------------------------------------------------
  // register map seen by the access engine
  // ------------------------------------------------------------
  localparam logic [7:0] ADDR_TX_ON    = 8'h00;
  localparam logic [7:0] ADDR_RX_ON    = 8'h08;
  localparam logic [7:0] ADDR_INT_EN   = 8'h60;
  localparam logic [7:0] ADDR_INT_STAT = 8'h61;
  localparam logic [7:0] ADDR_CHIP_ID  = 8'h6E;
  localparam logic [7:0] ADDR_CHIP_REV = 8'h6F;
  localparam logic [7:0] REG_RESET_VAL = 8'h00;
  localparam logic [7:0] CHAN_MASK     = 8'h3F;   // six channel bits

  // ------------------------------------------------------------
  // device access states
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    PCRP_IDLE = 2'b00,   // waiting for a strobe
    PCRP_BUSY = 2'b01,   // access in progress
    PCRP_DONE = 2'b10,   // completion shown, wait for strobe release
    PCRP_WAIT = 2'b11    // wait for select release
  } pcrp_dev_state_t;

  // host-side sequencer states
  typedef enum logic [2:0] {
    PCRP_H_IDLE = 3'b000,
    PCRP_H_SEL  = 3'b001,
    PCRP_H_STB  = 3'b010,
    PCRP_H_END  = 3'b011,
    PCRP_H_DESL = 3'b100
  } pcrp_host_state_t;

endpackage : pcrp_pkg

/* logic/pcrp_if.sv */
/*
  pcrp_if: pins between the host and the device port.
  assumes: this interface resolves the shared data wire from the two enables.
*/
`timescale 1ns/1ps
interface pcrp_if;
  logic [7:0] addr;        // register index from the host
  logic       cs_n;        // device select, active low
  logic       rd_n;        // read strobe, active low
  logic       wr_n;        // write strobe, active low
  logic       mode_sync;   // 0 asynchronous, 1 synchronous
  logic       bus_clk;     // host bus clock for synchronous mode
  logic       rst_n;       // device reset, active low
  logic [7:0] d_host_o;    // host data out
  logic       d_host_oe;   // host drives data
  logic [7:0] d_dev_o;     // device data out
  logic       d_dev_oe;    // device drives data
  logic [7:0] d_bus;       // resolved data wire
  logic       rdy_n;       // completion, active low
  logic       int_n;       // alarm interrupt, active low

  // wire resolution: device wins if both enable, then host, else pulled high
  assign d_bus = d_dev_oe ? d_dev_o : (d_host_oe ? d_host_o : 8'hFF);

  modport dev  (input addr, cs_n, rd_n, wr_n, mode_sync, bus_clk, rst_n, d_bus,
                output d_dev_o, d_dev_oe, rdy_n, int_n);
  modport host (output addr, cs_n, rd_n, wr_n, mode_sync, bus_clk, rst_n,
                d_host_o, d_host_oe, input d_bus, rdy_n, int_n);
endinterface : pcrp_if

/* logic/pcrp_dev.sv */
/*
  pcrp_dev: device end of the byte-wide host port, with a small register set.
  assumes: pins arrive asynchronously to clk; alarm events come from core logic on clk.
*/
// What this block does
// - mode pin picks async or sync access
// - low means async, high means sync
// - sync accesses timed by host bus clock
// - eight-bit shared data bus, direction by access
// - eight-bit index selects one register
// - accept strobes only while selected
// - host gives index then select, then strobe
// - read strobe starts read, enables drivers
// - read completion low once data valid
// - host ends read after completion seen
// - host drives data before write strobe
// - write strobe starts write, captures data
// - write completion low once byte stored
// - host deselects between commands
// - interrupt low on enabled alarm status change
// - interrupt releases after status read clears
// - low reset clears the device
// - reset held minimum; registers to defaults
// - sync completion within two clocks plus margin
`timescale 1ns/1ps
module pcrp_dev #(
  parameter logic [7:0] CHIP_ID  = 8'h5A,   // arbitrary identity value
  parameter logic [7:0] CHIP_REV = 8'h01    // arbitrary revision value
) (
  input  wire logic       clk,
  input  wire logic       resetn,
  pcrp_if.dev             bus,
  input  wire logic [5:0] alarm_evt,     // one-cycle alarm events per channel
  output logic      [5:0] tx_on,         // transmitter enables
  output logic      [5:0] rx_on          // receiver enables
);

  // ------------------------------------------------------------
  // input synchronisers
  // ------------------------------------------------------------
  logic [11:0] s1_r;    // first stage, read only by s2_r
  logic [11:0] s2_r;    // second stage, safe to use
  logic [7:0]  dat1_r;
  logic [7:0]  dat2_r;
  logic [7:0]  adr1_r;        // index, first stage
  logic [7:0]  adr2_r;        // index, second stage
  logic        bclk_prev_r;   // last synchronised bus clock level
  logic        rst1_r;
  logic        rst2_r;

  // two flops on every pin before any logic reads it
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      s1_r   <= 12'hFFF;
      s2_r   <= 12'hFFF;
      dat1_r <= 8'h00;
      dat2_r <= 8'h00;
      adr1_r <= 8'h00;
      adr2_r <= 8'h00;
      rst1_r <= 1'b0;
      rst2_r <= 1'b0;
    end
    else
    begin
      s1_r   <= {bus.bus_clk, bus.mode_sync, bus.rst_n, bus.cs_n, bus.rd_n, bus.wr_n,
                 6'h3F};
      s2_r   <= s1_r;
      dat1_r <= bus.d_bus;
      dat2_r <= dat1_r;
      adr1_r <= bus.addr;
      adr2_r <= adr1_r;
      rst1_r <= bus.rst_n;
      rst2_r <= rst1_r;
    end
  end

  // named views of the synchronised pins
  wire bclk_s  = s2_r[11];
  wire sync_s  = s2_r[10];
  wire cs_s    = s2_r[8];
  wire rd_s    = s2_r[7];
  wire wr_s    = s2_r[6];
  wire soft_rst = !rst2_r;

  // ------------------------------------------------------------
  // sampling of control pins
  // ------------------------------------------------------------
  logic cs_q_r;     // sampled select
  logic rd_q_r;     // sampled read strobe
  logic wr_q_r;     // sampled write strobe
  logic [7:0] addr_q_r;

  // rising edge of the bus clock after synchronisation
  wire bclk_rise = bclk_s && !bclk_prev_r;
  wire take_pins = sync_s ? bclk_rise : 1'b1;

  // index goes through two flops of its own, as deep as those of select and strobe, so all line up
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      // matches the synchroniser's reset level, so no false edge follows reset
      bclk_prev_r <= 1'b1;
      cs_q_r      <= 1'b1;
      rd_q_r      <= 1'b1;
      wr_q_r      <= 1'b1;
      addr_q_r    <= 8'h00;
    end
    else
    begin
      bclk_prev_r <= bclk_s;
      if (take_pins)
      begin
        cs_q_r   <= cs_s;
        rd_q_r   <= rd_s;
        wr_q_r   <= wr_s;
        addr_q_r <= adr2_r;
      end
    end
  end

  // ------------------------------------------------------------
  // access state machine
  // ------------------------------------------------------------
  pcrp_pkg::pcrp_dev_state_t st_r;
  pcrp_pkg::pcrp_dev_state_t st_nxt;
  logic       is_read_r;     // current access is a read
  logic [7:0] dout_r;        // data driven on reads
  logic       doe_r;         // data driver enable
  logic       rdy_n_r;       // completion
  logic [7:0] addr_l_r;      // index latched at strobe

  wire rd_req = !cs_q_r && !rd_q_r;
  wire wr_req = !cs_q_r && !wr_q_r && rd_q_r;
  wire released = cs_q_r || (is_read_r ? rd_q_r : wr_q_r);

  always_comb
  begin
    st_nxt = st_r;
    case (st_r)
      pcrp_pkg::PCRP_IDLE: if (rd_req || wr_req) st_nxt = pcrp_pkg::PCRP_BUSY;
      // one cycle to look up or store
      pcrp_pkg::PCRP_BUSY: st_nxt = pcrp_pkg::PCRP_DONE;
      pcrp_pkg::PCRP_DONE: if (released) st_nxt = pcrp_pkg::PCRP_WAIT;
      pcrp_pkg::PCRP_WAIT: if (cs_q_r) st_nxt = pcrp_pkg::PCRP_IDLE;
      default:             st_nxt = pcrp_pkg::PCRP_IDLE;
    endcase
  end

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  logic [5:0] int_en_r;     // interrupt enables
  logic [5:0] int_st_r;     // sticky alarm status
  logic       int_n_r;

  wire hit_tx   = addr_l_r == pcrp_pkg::ADDR_TX_ON;
  wire hit_rx   = addr_l_r == pcrp_pkg::ADDR_RX_ON;
  wire hit_en   = addr_l_r == pcrp_pkg::ADDR_INT_EN;
  wire hit_st   = addr_l_r == pcrp_pkg::ADDR_INT_STAT;
  wire hit_id   = addr_l_r == pcrp_pkg::ADDR_CHIP_ID;
  wire hit_rev  = addr_l_r == pcrp_pkg::ADDR_CHIP_REV;
  wire in_busy  = st_r == pcrp_pkg::PCRP_BUSY;
  wire do_wr    = in_busy && !is_read_r;
  wire do_rd    = in_busy && is_read_r;
  // unmapped indices read as zero
  wire [7:0] rd_mux = hit_tx  ? {2'b00, tx_on}    :
                      hit_rx  ? {2'b00, rx_on}    :
                      hit_en  ? {2'b00, int_en_r} :
                      hit_st  ? {2'b00, int_st_r} :
                      hit_id  ? CHIP_ID           :
                      hit_rev ? CHIP_REV          : 8'h00;
  // read of status clears, a new event wins
  wire [5:0] st_clr = (do_rd && hit_st) ? int_st_r : 6'h00;

  // state, data path and completion
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      st_r      <= pcrp_pkg::PCRP_IDLE;
      is_read_r <= 1'b0;
      addr_l_r  <= 8'h00;
      dout_r    <= 8'h00;
      doe_r     <= 1'b0;
      rdy_n_r   <= 1'b1;
    end
    else if (soft_rst)
    begin
      st_r    <= pcrp_pkg::PCRP_IDLE;
      doe_r   <= 1'b0;
      rdy_n_r <= 1'b1;
    end
    else
    begin
      st_r <= st_nxt;
      if (st_r == pcrp_pkg::PCRP_IDLE && (rd_req || wr_req))
      begin
        is_read_r <= rd_req;
        addr_l_r  <= addr_q_r;
        doe_r     <= rd_req;
      end
      if (do_rd)
        dout_r <= rd_mux;
      // completion after data valid or stored
      // five clocks after the strobe pin in async, just inside the six-cycle budget
      if (in_busy)
        rdy_n_r <= 1'b0;
      if (st_r == pcrp_pkg::PCRP_DONE && released)
      begin
        rdy_n_r <= 1'b1;
        doe_r   <= 1'b0;
      end
    end
  end

  // register file and interrupt
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      tx_on    <= pcrp_pkg::REG_RESET_VAL[5:0];
      rx_on    <= pcrp_pkg::REG_RESET_VAL[5:0];
      int_en_r <= pcrp_pkg::REG_RESET_VAL[5:0];
      int_st_r <= pcrp_pkg::REG_RESET_VAL[5:0];
      int_n_r  <= 1'b1;
    end
    else if (soft_rst)
    begin
      tx_on    <= pcrp_pkg::REG_RESET_VAL[5:0];
      rx_on    <= pcrp_pkg::REG_RESET_VAL[5:0];
      int_en_r <= pcrp_pkg::REG_RESET_VAL[5:0];
      int_st_r <= pcrp_pkg::REG_RESET_VAL[5:0];
      int_n_r  <= 1'b1;
    end
    else
    begin
      if (do_wr && hit_tx) tx_on <= dat2_r[5:0];
      if (do_wr && hit_rx) rx_on <= dat2_r[5:0];
      if (do_wr && hit_en) int_en_r <= dat2_r[5:0];
      int_st_r <= (int_st_r & ~st_clr) | alarm_evt;
      int_n_r  <= !(|(((int_st_r & ~st_clr) | alarm_evt) & int_en_r));
    end
  end

  // pins come straight from flops
  assign bus.d_dev_o  = dout_r;
  assign bus.d_dev_oe = doe_r;
  assign bus.rdy_n    = rdy_n_r;
  assign bus.int_n    = int_n_r;

endmodule : pcrp_dev

/* logic/pcrp_host.sv */
/*
  pcrp_host: host end; runs one read or write per request and returns data.
  assumes: requests come from logic on clk; device pins are asynchronous.
*/
`timescale 1ns/1ps
module pcrp_host (
  input  wire logic       clk,
  input  wire logic       resetn,
  pcrp_if.host            bus,
  input  wire logic       sync_mode,   // selects synchronous bus timing
  input  wire logic       req,         // one-cycle access request
  input  wire logic       req_write,   // 1 write, 0 read
  input  wire logic [7:0] req_addr,
  input  wire logic [7:0] req_wdata,
  input  wire logic       dev_reset,   // level: hold device in reset
  output logic            busy,        // access in progress
  output logic            done,        // one-cycle completion pulse
  output logic      [7:0] rdata,       // read data, valid with done
  output logic            irq          // synchronised device interrupt
);

  // ------------------------------------------------------------
  // pin synchronisers and bus clock divider
  // ------------------------------------------------------------
  logic [1:0] rdy1_r;
  logic [1:0] rdy2_r;
  logic [7:0] d1_r;
  logic [7:0] d2_r;
  logic [1:0] div_r;
  logic       bclk_r;

  // two flops before use; bus clock made by divider
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rdy1_r <= 2'h3;
      rdy2_r <= 2'h3;
      d1_r   <= 8'h00;
      d2_r   <= 8'h00;
      div_r  <= 2'h0;
      bclk_r <= 1'b0;
    end
    else
    begin
      rdy1_r <= {bus.rdy_n, bus.int_n};
      rdy2_r <= rdy1_r;
      d1_r   <= bus.d_bus;
      d2_r   <= d1_r;
      div_r  <= div_r + 2'h1;
      if (div_r == 2'(pcrp_pkg::BCLK_DIV - 1))
      begin
        bclk_r <= !bclk_r;
        div_r  <= 2'h0;
      end
    end
  end

  // ------------------------------------------------------------
  // access sequencer
  // ------------------------------------------------------------
  pcrp_pkg::pcrp_host_state_t hs_r;
  logic       cs_n_r;
  logic       rd_n_r;
  logic       wr_n_r;
  logic [7:0] a_r;
  logic [7:0] wd_r;
  logic       doe_r;
  logic       wr_op_r;
  logic       rst_n_r;
  logic [2:0] gap_r;         // cycles the select has stood high, saturating
  logic [9:0] rcnt_r;        // device reset stretch counter
  wire        rdy_s = !rdy2_r[1];
  // one bus clock period: a shorter deselect could slip between sync samples
  localparam int GAP_CYC = 2 * pcrp_pkg::BCLK_DIV;
  wire        gap_ok = gap_r >= 3'(GAP_CYC);

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      hs_r <= pcrp_pkg::PCRP_H_IDLE;
      cs_n_r <= 1'b1;
      rd_n_r <= 1'b1;
      wr_n_r <= 1'b1;
      a_r <= 8'h00;
      wd_r <= 8'h00;
      doe_r <= 1'b0;
      wr_op_r <= 1'b0;
      busy <= 1'b0;
      done <= 1'b0;
      rdata <= 8'h00;
      irq <= 1'b0;
      rst_n_r <= 1'b0;
      gap_r <= 3'h0;
      rcnt_r <= 10'(pcrp_pkg::RESET_MIN_CYC);
    end
    else
    begin
      done    <= 1'b0;
      irq     <= !rdy2_r[0];
      if (dev_reset)
        rcnt_r <= 10'(pcrp_pkg::RESET_MIN_CYC);
      else if (rcnt_r != 10'h000)
        rcnt_r <= rcnt_r - 10'h001;
      rst_n_r <= !dev_reset && (rcnt_r == 10'h000);
      // count select high time, saturating
      if (!cs_n_r)
        gap_r <= 3'h0;
      else if (!gap_ok)
        gap_r <= gap_r + 3'h1;
      case (hs_r)
        pcrp_pkg::PCRP_H_IDLE:
          if (req)
          begin
            a_r <= req_addr;
            wd_r <= req_wdata;
            wr_op_r <= req_write;
            busy <= 1'b1;
            hs_r <= pcrp_pkg::PCRP_H_SEL;
          end
        pcrp_pkg::PCRP_H_SEL:
          if (gap_ok)
          begin
            cs_n_r <= 1'b0;
            doe_r  <= wr_op_r;
            hs_r   <= pcrp_pkg::PCRP_H_STB;
          end
        pcrp_pkg::PCRP_H_STB:
        begin
          rd_n_r <= wr_op_r;
          wr_n_r <= !wr_op_r;
          if (!rd_n_r || !wr_n_r)
            if (rdy_s)
            begin
              rdata <= d2_r;
              hs_r  <= pcrp_pkg::PCRP_H_END;
            end
        end
        pcrp_pkg::PCRP_H_END:
        begin
          rd_n_r <= 1'b1;
          wr_n_r <= 1'b1;
          doe_r  <= 1'b0;
          hs_r   <= pcrp_pkg::PCRP_H_DESL;
        end
        pcrp_pkg::PCRP_H_DESL:
          if (!rdy_s)
          begin
            cs_n_r <= 1'b1;
            busy   <= 1'b0;
            done   <= 1'b1;
            hs_r   <= pcrp_pkg::PCRP_H_IDLE;
          end
        default: hs_r <= pcrp_pkg::PCRP_H_IDLE;
      endcase
    end
  end

  // pins from flops, mode_sync straight from sync_mode; bus clock supplied
  assign bus.addr      = a_r;
  assign bus.cs_n      = cs_n_r;
  assign bus.rd_n      = rd_n_r;
  assign bus.wr_n      = wr_n_r;
  assign bus.mode_sync = sync_mode;
  assign bus.bus_clk   = bclk_r;
  assign bus.rst_n     = rst_n_r;
  assign bus.d_host_o  = wd_r;
  assign bus.d_host_oe = doe_r;

endmodule : pcrp_host

/* bench/pcrp_monitor.sv */
/*
  pcrp_monitor: timing checks on the pins between host and device ends.
  assumes: placed beside the interface; every pin it takes is sampled on clk.
*/
`timescale 1ns/1ps
module pcrp_monitor (
  input wire logic       clk,
  input wire logic       resetn,
  input wire logic [7:0] addr,
  input wire logic       cs_n,
  input wire logic       rd_n,
  input wire logic       wr_n,
  input wire logic       mode_sync,
  input wire logic       d_host_oe,
  input wire logic       d_dev_oe,
  input wire logic       rdy_n
);
  // ------------------------------------------------------------
  // limits in clk cycles
  // ------------------------------------------------------------
  localparam int ASYNC_LIM = 6;    // 65 ns strobe to completion, async
  localparam int SYNC_LIM  = 8;    // two 40 ns bus clocks plus 5 ns, sync
  localparam int DROP_LIM  = 12;   // strobe release to idle pins

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  // ------------------------------------------------------------
  // sequences
  // ------------------------------------------------------------
  // a strobe falls while the device is selected
  sequence s_start;
    !cs_n && $fell(rd_n && wr_n);
  endsequence
  // completion released and data drivers off
  sequence s_idle;
    rdy_n && !d_dev_oe;
  endsequence

  // ------------------------------------------------------------
  // properties
  // ------------------------------------------------------------
  property p_async_ack;
    s_start ##0 !mode_sync |-> ##[1:ASYNC_LIM] !rdy_n;
  endproperty
  property p_sync_ack;
    s_start ##0 mode_sync |-> ##[1:SYNC_LIM] !rdy_n;
  endproperty
  // release is bounded, since a stuck completion would hang the host
  property p_release;
    $rose(rd_n && wr_n) |-> ##[1:DROP_LIM] s_idle;
  endproperty
  property p_unselected;
    cs_n |-> s_idle;
  endproperty
  property p_stands;
    $rose(rdy_n) |-> cs_n || (rd_n && wr_n);
  endproperty
  property p_no_clash;
    d_dev_oe |-> !d_host_oe;
  endproperty
  property p_write_quiet;
    !cs_n && !wr_n |-> !d_dev_oe;
  endproperty
  property p_order;
    $fell(rd_n && wr_n) |-> !cs_n && !$past(cs_n);
  endproperty
  property p_wdata;
    $fell(wr_n) |-> d_host_oe;
  endproperty
  property p_addr;
    !cs_n && !$past(cs_n) |-> $stable(addr);
  endproperty

  a_async_ack: assert property (p_async_ack)
    else $error("async completion late");
  a_sync_ack: assert property (p_sync_ack)
    else $error("sync completion late");
  a_release: assert property (p_release)
    else $error("completion not released");
  a_unselected: assert property (p_unselected)
    else $error("device active while unselected");
  a_stands: assert property (p_stands)
    else $error("completion dropped early");
  a_no_clash: assert property (p_no_clash)
    else $error("both ends drive data");
  a_write_quiet: assert property (p_write_quiet)
    else $error("device drives during write");
  a_order: assert property (p_order)
    else $error("strobe without prior select");
  a_wdata: assert property (p_wdata)
    else $error("write strobe without data");
  a_addr: assert property (p_addr)
    else $error("index moved while selected");
endmodule : pcrp_monitor

/* bench/pcrp_test.sv */
/*
  pcrp_test: joins host and device ends, runs register accesses in both modes.
  assumes: design files and pcrp_monitor compiled first; one 100 MHz clock.
*/
`timescale 1ns/1ps
module pcrp_test;
  // ------------------------------------------------------------
  // signals
  // ------------------------------------------------------------
  localparam logic [7:0] ID_VAL  = 8'hA5;   // arbitrary identity value
  localparam logic [7:0] REV_VAL = 8'h03;   // arbitrary revision value
  logic       clk;
  logic       resetn;
  logic       sync_mode;
  logic       req;
  logic       req_write;
  logic [7:0] req_addr;
  logic [7:0] req_wdata;
  logic       dev_reset;
  logic [5:0] alarm_evt;
  logic       busy;
  logic       done;
  logic [7:0] rdata;
  logic       irq;
  logic [5:0] tx_on;
  logic [5:0] rx_on;
  int         miscompares;
  int         n_tests;
  logic [7:0] got;                          // byte of the last access
  logic [7:0] ra [6] = '{pcrp_pkg::ADDR_TX_ON, pcrp_pkg::ADDR_RX_ON, pcrp_pkg::ADDR_INT_EN,
                         pcrp_pkg::ADDR_INT_STAT, pcrp_pkg::ADDR_CHIP_ID,
                         pcrp_pkg::ADDR_CHIP_REV};
  logic [7:0] re [6] = '{8'h00, 8'h00, 8'h00, 8'h00, ID_VAL, REV_VAL};

  pcrp_if u_pcrp_if ();
  pcrp_dev #(.CHIP_ID(ID_VAL), .CHIP_REV(REV_VAL)) u_pcrp_dev (
    .clk       (clk),
    .resetn    (resetn),
    .bus       (u_pcrp_if.dev),
    .alarm_evt (alarm_evt),
    .tx_on     (tx_on),
    .rx_on     (rx_on)
  );
  pcrp_host u_pcrp_host (
    .clk       (clk),
    .resetn    (resetn),
    .bus       (u_pcrp_if.host),
    .sync_mode (sync_mode),
    .req       (req),
    .req_write (req_write),
    .req_addr  (req_addr),
    .req_wdata (req_wdata),
    .dev_reset (dev_reset),
    .busy      (busy),
    .done      (done),
    .rdata     (rdata),
    .irq       (irq)
  );
  pcrp_monitor u_pcrp_monitor (
    .clk       (clk),
    .resetn    (resetn),
    .addr      (u_pcrp_if.addr),
    .cs_n      (u_pcrp_if.cs_n),
    .rd_n      (u_pcrp_if.rd_n),
    .wr_n      (u_pcrp_if.wr_n),
    .mode_sync (u_pcrp_if.mode_sync),
    .d_host_oe (u_pcrp_if.d_host_oe),
    .d_dev_oe  (u_pcrp_if.d_dev_oe),
    .rdy_n     (u_pcrp_if.rdy_n)
  );

  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  // verdict and end of run
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : stop_test

  // byte compare, four-state
  task automatic check8(input logic [7:0] g, input logic [7:0] e, input string what);
    n_tests++;
    if (g !== e)
    begin
      miscompares++;
      $display("CHECK FAILED at %0t: %s got %h want %h", $time, what, g, e);
    end
  endtask : check8

  // one host request; waits a bounded time for the done pulse
  task automatic access(input logic wr, input logic [7:0] a, input logic [7:0] wd);
    bit seen;
    seen = 1'b0;
    @(negedge clk);
    req = 1'b1;
    req_write = wr;
    req_addr = a;
    req_wdata = wd;
    @(negedge clk);
    req = 1'b0;
    for (int i = 0; i < 200 && !seen; i++)
    begin
      @(posedge clk);
      #1;
      if (done === 1'b1)
      begin
        seen = 1'b1;
        got = rdata;
      end
    end
    check8({7'h00, seen}, 8'h01, "completion");
    check8({7'h00, busy}, 8'h00, "busy after done");
  endtask : access

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    access(1'b0, a, 8'h00);
    check8(got, e, "read data");
  endtask : rd_chk

  // one-cycle alarm events, then time for the interrupt to settle
  task automatic pulse(input logic [5:0] e);
    @(negedge clk);
    alarm_evt = e;
    @(negedge clk);
    alarm_evt = 6'h00;
    repeat (8) @(negedge clk);
  endtask : pulse

  // ------------------------------------------------------------
  // clock, watchdog, main sequence
  // ------------------------------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // full run needs well under 5000 cycles
  initial
  begin
    #300000;
    miscompares++;
    stop_test();
  end

  initial
  begin
    miscompares = 0;
    n_tests = 0;
    resetn = 1'b0;
    sync_mode = 1'b0;
    req = 1'b0;
    req_write = 1'b0;
    req_addr = 8'h00;
    req_wdata = 8'h00;
    dev_reset = 1'b0;
    alarm_evt = 6'h00;
    repeat (8) @(posedge clk);
    @(negedge clk);
    resetn = 1'b1;
    // the host stretches the device reset to its least pulse
    repeat (pcrp_pkg::RESET_MIN_CYC + 16) @(negedge clk);
    // pass 0 async, pass 1 sync; mode only moves while idle
    for (int m = 0; m < 2; m++)
    begin
      sync_mode = m[0];
      repeat (4) @(negedge clk);
      for (int k = 0; k < 6; k++)
        rd_chk(ra[k], re[k]);
      access(1'b1, pcrp_pkg::ADDR_TX_ON, 8'hFF);
      access(1'b1, pcrp_pkg::ADDR_RX_ON, 8'h2A);
      rd_chk(pcrp_pkg::ADDR_TX_ON, 8'h3F);
      rd_chk(pcrp_pkg::ADDR_RX_ON, 8'h2A);
      check8({2'b00, tx_on}, 8'h3F, "tx enables");
      check8({2'b00, rx_on}, 8'h2A, "rx enables");
      // read-only and unmapped places keep their values
      access(1'b1, pcrp_pkg::ADDR_CHIP_ID, 8'h00);
      rd_chk(pcrp_pkg::ADDR_CHIP_ID, ID_VAL);
      access(1'b1, 8'h62, 8'h55);
      rd_chk(8'h62, 8'h00);
      // masked event, enabled event, clear by reading
      access(1'b1, pcrp_pkg::ADDR_INT_EN, 8'h01);
      pulse(6'h02);
      check8({7'h00, irq}, 8'h00, "masked alarm");
      rd_chk(pcrp_pkg::ADDR_INT_STAT, 8'h02);
      pulse(6'h01);
      check8({7'h00, irq}, 8'h01, "alarm");
      rd_chk(pcrp_pkg::ADDR_INT_STAT, 8'h01);
      rd_chk(pcrp_pkg::ADDR_INT_STAT, 8'h00);
      check8({7'h00, irq}, 8'h00, "alarm released");
      // device reset pin returns registers to defaults
      @(negedge clk);
      dev_reset = 1'b1;
      repeat (10) @(negedge clk);
      dev_reset = 1'b0;
      repeat (pcrp_pkg::RESET_MIN_CYC + 16) @(negedge clk);
      check8({2'b00, tx_on}, 8'h00, "tx after reset");
      rd_chk(pcrp_pkg::ADDR_RX_ON, 8'h00);
    end
    stop_test();
  end
endmodule : pcrp_test
